//--- dstc_checker.sv
/* port assertions for dstc_top.
   assumes it is bound into dstc_top and handed the same parameters. */
`timescale 1ns/100ps
`include "dstc_defines.vh"
module dstc_checker #(
  parameter TON_CYC = 50,
  parameter TOFF_CYC = 500
) (
  // bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // pins
  input wire tone_output_pin,
  input wire tone_tx_path_pin,
  input wire tone_tx_path_on,
  input wire tone_detect_input,
  input wire detected_tone_output_o,
  input wire detected_tone_output_oe,
  input wire power_enable,
  input wire [3:0] output_level,
  input wire [3:0] boost_rail,
  input wire overtemp_mon
);
  localparam int HALF = `DSTC_TONE_HALF_CYC;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // high-run length of the tone, to bound each high half period
  logic [15:0] hi_cnt_r;
  logic [15:0] hi_cnt_nxt;
  assign hi_cnt_nxt = tone_output_pin ? hi_cnt_r + 16'h0001 : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt_r <= 16'h0000;
    else
      hi_cnt_r <= hi_cnt_nxt;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after access");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held over two cycles");
  property p_refuse;
    pslverr |-> pready && paddr != 12'h000 && paddr != 12'h004;
  endproperty
  a_refuse: assert property (p_refuse) else $error("error on a mapped address");
  property p_dto_low;
    detected_tone_output_o == 1'b0;
  endproperty
  a_dto_low: assert property (p_dto_low) else $error("detector pin drives high");
  property p_dto_on;
    $rose(tone_detect_input) |-> ##[1:8] detected_tone_output_oe;
  endproperty
  a_dto_on: assert property (p_dto_on) else $error("detector pin not pulled low");
  property p_force;
    output_level == 4'h8 |-> boost_rail == 4'h8;
  endproperty
  a_force: assert property (p_force) else $error("forced level without forced rail");
  property p_rail;
    output_level != 4'h0 && output_level != 4'h8 |->
      boost_rail == {2'b00, output_level[1], output_level[0] | output_level[2]};
  endproperty
  a_rail: assert property (p_rail) else $error("boost rail follows the fast pin");
  property p_half;
    tone_output_pin |-> hi_cnt_r <= HALF;
  endproperty
  a_half: assert property (p_half) else $error("tone half period too long");
  property p_ot;
    $rose(overtemp_mon) |-> ##[1:8] !power_enable;
  endproperty
  a_ot: assert property (p_ot) else $error("power kept on when overheated");
  property p_txon;
    $rose(tone_tx_path_pin) |-> ##[1:8] tone_tx_path_on;
  endproperty
  a_txon: assert property (p_txon) else $error("tx path pin ignored");
  c_err: cover property (pslverr);
  c_tone: cover property ($rose(tone_output_pin));
  c_force: cover property (output_level == 4'h8);
endmodule

//--- dstc_defines.vh
/*
 * constants of the dish supply tone control block: register map, field
 * positions, reset values and timing counts.
 * assumes a 50 MHz pclk.
 */
`ifndef DSTC_DEFINES_VH
`define DSTC_DEFINES_VH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define DSTC_CTRL_ADDR 12'h000
`define DSTC_STAT_ADDR 12'h004

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define DSTC_BIT_EN 0
`define DSTC_BIT_VOLTAGE_SELECT_BIT 1
`define DSTC_BIT_BOOST 2
`define DSTC_BIT_TONE 3
`define DSTC_BIT_TXON 4
`define DSTC_BIT_PLS 5
`define DSTC_BIT_ITH 6
`define DSTC_BIT_HIV 7
`define DSTC_CTRL_RST 8'h00

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define DSTC_ST_LOWI 0
`define DSTC_ST_UV 1
`define DSTC_ST_TF 2
`define DSTC_ST_OT 3
`define DSTC_ST_OL 4
`define DSTC_ST_EN 5
`define DSTC_ST_VOLTAGE_SELECT_BIT 6
`define DSTC_ST_BOOST 7

// ----------------------------------------------------------------------
// level codes: bit0 sel, bit1 boost, bit2 fast-low, bit3 forced high
// ----------------------------------------------------------------------
`define DSTC_LVL_OFF 4'h0

// ----------------------------------------------------------------------
// timing (tone half period in ns, overload intervals in ms)
// ----------------------------------------------------------------------
`define DSTC_TONE_HALF_NS 22727
`define DSTC_CLK_NS 20
`define DSTC_TONE_HALF_CYC ((`DSTC_TONE_HALF_NS + `DSTC_CLK_NS - 1) / `DSTC_CLK_NS)
`define DSTC_TON_MS 90
`define DSTC_TOFF_MS 900
`define DSTC_TON_CYC (`DSTC_TON_MS * 50000)
`define DSTC_TOFF_CYC (`DSTC_TOFF_MS * 50000)
`define DSTC_KEY_TMO_CYC 3000

`endif

//--- dstc_key_src.sv
/* host keying source: square wave on the keying pin while enabled.
   assumes the bench enables it only with the tone path switched on. */
`timescale 1ns/100ps
module dstc_key_src #(
  parameter int HALF_NS = 80
) (
  input wire enable,
  output logic key
);
  // stands still low between bursts, as a host keying line does
  initial begin
    key = 1'b0;
    forever begin
      wait (enable === 1'b1);
      #(HALF_NS) key = ~key;
      if (enable !== 1'b1)
        key = 1'b0;
    end
  end
endmodule

//--- dstc_top.v
/*
 * dish supply tone control: apb control/status registers, tone gating from
 * the gate pin, keying pin or continuous bit, output level selection,
 * diagnostic flags and pulsed overload timer.
 * assumes analog monitors arrive as asynchronous levels and are synchronised
 * here; the keying input is a 22 khz logic square wave.
 */
//
// Operation
// - tone starts when gate pin asserts or continuous bit is set.
// - gate pin: tone on half cycle after assert, off one cycle after release.
// - keying pin: on 1.5 cycles after detection, off 2 cycles after it stops.
// - keying only times the tone; waveform always from own generator.
// - control register takes 8 bits; read gives five flags plus en, select, boost.
// - enable low disables power; enable high selects 13 or 18 volts.
// - boost bit adds one volt to selected level.
// - fast level pin low gives 13.4 V, high 18.5 or 19.5 V.
// - fast level pin affects linear stage only; boost rail ignores it.
// - all diagnostic flags read low with no fault.
// - undervoltage flag set when output low; valid only with boost clear.
// - tone fault flag set when detected tone out of limits.
// - low current flag always active; threshold picked by select bit. code leaves the ith bit unused; flag is en & lowi_s.
// - force bit drives output 22 V and rail 22.75 V regardless of select.
// - limit select low gives dynamic protection, high static clamp.
// - dynamic: 90 ms on, 900 ms off with overload flag, retry repeatedly.
// - full on interval without overload resumes normal and clears flag.
// - static: overload flag follows clamp limit condition.
// - over-temperature shuts converter and regulator, flag until cooled.
// - detected tone output pulled low while tone is detected.
`timescale 1ns/100ps
`include "dstc_defines.vh"

module dstc_top #(
  parameter TON_CYC = `DSTC_TON_CYC,
  parameter TOFF_CYC = `DSTC_TOFF_CYC
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // tone pins
  input wire tone_gate_input,
  input wire external_keying_input,
  input wire tone_tx_path_pin,
  output reg tone_output_pin,
  output reg tone_tx_path_on,
  // detector
  input wire tone_detect_input,
  output reg detected_tone_output_o,
  output reg detected_tone_output_oe,
  // level control
  input wire fast_level_pin,
  output reg power_enable,
  output reg [3:0] output_level,
  output reg [3:0] boost_rail,
  // analog monitors
  input wire undervoltage_mon,
  input wire tone_limit_mon,
  input wire low_current_mon,
  input wire overload_mon,
  input wire overtemp_mon
);

  localparam [14:0] HALF_CYC = `DSTC_TONE_HALF_CYC;
  localparam [11:0] KEY_TMO = `DSTC_KEY_TMO_CYC;
  // delays in pclk cycles; keying off delay has the idle timeout subtracted
  localparam [15:0] GATE_ON_C = `DSTC_TONE_HALF_CYC;
  localparam [15:0] GATE_OFF_C = 2 * `DSTC_TONE_HALF_CYC;
  localparam [15:0] KEY_ON_C = 3 * `DSTC_TONE_HALF_CYC;
  localparam [15:0] KEY_OFF_C = 4 * `DSTC_TONE_HALF_CYC - `DSTC_KEY_TMO_CYC;
  localparam [25:0] TON_C = TON_CYC;
  localparam [25:0] TOFF_C = TOFF_CYC;
  localparam [2:0] OL_IDLE = 3'b001;
  localparam [2:0] OL_ON = 3'b010;
  localparam [2:0] OL_OFF = 3'b100;

  // ----------------------------------------------------------------------
  // input synchronisers: three stages, a change counts when 2 and 3 agree
  // ----------------------------------------------------------------------
  localparam NIN = 9;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] s1_r;
  reg [NIN-1:0] s2_r;
  reg [NIN-1:0] s3_r;
  reg [NIN-1:0] in_r;
  assign raw_in = {overtemp_mon, overload_mon, low_current_mon, tone_limit_mon,
                   undervoltage_mon, tone_detect_input, fast_level_pin,
                   external_keying_input, tone_gate_input};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          in_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            in_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  // txon pin gets its own chain so the map above stays one bit per monitor
  reg tx1_r;
  reg tx2_r;
  reg tx3_r;
  reg txp_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx1_r <= 1'b0;
      tx2_r <= 1'b0;
      tx3_r <= 1'b0;
      txp_r <= 1'b0;
    end else begin
      tx1_r <= tone_tx_path_pin;
      tx2_r <= tx1_r;
      tx3_r <= tx2_r;
      if (tx2_r == tx3_r) begin
        txp_r <= tx3_r;
      end
    end
  end
  wire gate_s = in_r[0];
  wire key_s = in_r[1];
  wire fast_s = in_r[2];
  wire det_s = in_r[3];
  wire uv_s = in_r[4];
  wire tlim_s = in_r[5];
  wire lowi_s = in_r[6];
  wire olm_s = in_r[7];
  wire ot_s = in_r[8];

  // ----------------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------------
  reg [7:0] ctrl_r;
  wire [7:0] status;
  wire apb_acc = psel & penable;
  wire hit_ctrl = (paddr == `DSTC_CTRL_ADDR);
  wire hit_stat = (paddr == `DSTC_STAT_ADDR);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DSTC_CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // one wait state: answer comes in the second access cycle
      pready <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~(hit_ctrl | hit_stat);
      if (apb_acc & pready & pwrite & hit_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
      if (apb_acc & ~pready & ~pwrite) begin
        if (hit_ctrl) begin
          prdata <= {24'h00_0000, ctrl_r};
        end else if (hit_stat) begin
          prdata <= {24'h00_0000, status};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
  wire en_b = ctrl_r[`DSTC_BIT_EN];
  wire voltage_select_bit_b = ctrl_r[`DSTC_BIT_VOLTAGE_SELECT_BIT];
  wire boost_b = ctrl_r[`DSTC_BIT_BOOST];
  wire continuous_tone_bit = ctrl_r[`DSTC_BIT_TONE];
  wire pulsed_limit_select = ctrl_r[`DSTC_BIT_PLS];
  wire current_threshold_select = ctrl_r[`DSTC_BIT_ITH];
  wire hiv_b = ctrl_r[`DSTC_BIT_HIV];

  // ----------------------------------------------------------------------
  // tone generator: 22 khz from pclk
  // ----------------------------------------------------------------------
  reg [14:0] half_cnt_r;
  reg phase_r;
  wire tone_req;
  wire half_tick = (half_cnt_r == HALF_CYC - 15'd1);
  // restarts on each request so a burst opens with a full high half period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r <= 15'd0;
      phase_r <= 1'b1;
    end else if (!tone_req) begin
      half_cnt_r <= 15'd0;
      phase_r <= 1'b1;
    end else if (half_tick) begin
      half_cnt_r <= 15'd0;
      phase_r <= ~phase_r;
    end else begin
      half_cnt_r <= half_cnt_r + 15'd1;
    end
  end

  // ----------------------------------------------------------------------
  // gate and keying delays, counted in pclk cycles
  // ----------------------------------------------------------------------
  reg [15:0] gate_dly_r;
  reg gate_on_r;
  reg [15:0] key_dly_r;
  reg key_on_r;
  reg key_prev_r;
  reg [11:0] key_idle_r;
  wire key_edge = key_s & ~key_prev_r;
  wire key_act = (key_idle_r != 12'd0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_dly_r <= 16'd0;
      gate_on_r <= 1'b0;
      key_dly_r <= 16'd0;
      key_on_r <= 1'b0;
      key_prev_r <= 1'b0;
      key_idle_r <= 12'd0;
    end else begin
      key_prev_r <= key_s;
      // keying seen as active while rising edges keep coming
      if (key_edge) begin
        key_idle_r <= KEY_TMO;
      end else if (key_act) begin
        key_idle_r <= key_idle_r - 12'd1;
      end
      // gate: on after 1 half period, off after 2
      if (gate_s == gate_on_r) begin
        gate_dly_r <= 16'd0;
      end else if (gate_dly_r == (gate_on_r ? GATE_OFF_C : GATE_ON_C) - 16'd1) begin
        gate_on_r <= gate_s;
        gate_dly_r <= 16'd0;
      end else begin
        gate_dly_r <= gate_dly_r + 16'd1;
      end
      // keying: on after 3 half periods, off 4 half periods after the last edge
      if (key_act == key_on_r) begin
        key_dly_r <= 16'd0;
      end else if (key_dly_r == (key_on_r ? KEY_OFF_C : KEY_ON_C) - 16'd1) begin
        key_on_r <= key_act;
        key_dly_r <= 16'd0;
      end else begin
        key_dly_r <= key_dly_r + 16'd1;
      end
    end
  end
  assign tone_req = gate_on_r | key_on_r | continuous_tone_bit;

  // ----------------------------------------------------------------------
  // tone output and path enable
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_output_pin <= 1'b0;
      tone_tx_path_on <= 1'b0;
    end else begin
      // waveform is the internal phase, never the keying pin itself
      tone_output_pin <= tone_req & phase_r & ~ot_s;
      tone_tx_path_on <= ctrl_r[`DSTC_BIT_TXON] | txp_r;
    end
  end

  // ----------------------------------------------------------------------
  // dynamic overload timer
  // ----------------------------------------------------------------------
  reg [2:0] ol_st_r;
  reg [25:0] ol_cnt_r;
  reg ol_seen_r;
  reg ol_flag_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ol_st_r <= OL_IDLE;
      ol_cnt_r <= 26'd0;
      ol_seen_r <= 1'b0;
      ol_flag_r <= 1'b0;
    end else if (pulsed_limit_select | ~en_b) begin
      ol_st_r <= OL_IDLE;
      ol_cnt_r <= 26'd0;
      ol_seen_r <= 1'b0;
      ol_flag_r <= en_b & olm_s;
    end else begin
      case (ol_st_r)
        OL_IDLE: begin
          ol_flag_r <= 1'b0;
          if (olm_s) begin
            ol_st_r <= OL_ON;
            ol_cnt_r <= 26'd0;
            ol_seen_r <= 1'b1;
          end
        end
        OL_ON: begin
          if (olm_s) begin
            ol_seen_r <= 1'b1;
          end
          if (ol_cnt_r == TON_C - 26'd1) begin
            ol_cnt_r <= 26'd0;
            if (ol_seen_r | olm_s) begin
              ol_st_r <= OL_OFF;
              ol_flag_r <= 1'b1;
            end else begin
              ol_st_r <= OL_IDLE;
              ol_flag_r <= 1'b0;
            end
          end else begin
            ol_cnt_r <= ol_cnt_r + 26'd1;
          end
        end
        OL_OFF: begin
          if (ol_cnt_r == TOFF_C - 26'd1) begin
            ol_cnt_r <= 26'd0;
            ol_seen_r <= 1'b0;
            ol_st_r <= OL_ON;
          end else begin
            ol_cnt_r <= ol_cnt_r + 26'd1;
          end
        end
        default: begin
          ol_st_r <= OL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // level selection and diagnostics
  // ----------------------------------------------------------------------
  reg [4:0] flag_r;
  wire power_ok = en_b & ~ot_s & (ol_st_r != OL_OFF);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_enable <= 1'b0;
      output_level <= `DSTC_LVL_OFF;
      boost_rail <= `DSTC_LVL_OFF;
      flag_r <= 5'h00;
      detected_tone_output_o <= 1'b0;
      detected_tone_output_oe <= 1'b0;
    end else begin
      power_enable <= power_ok;
      if (!power_ok) begin
        output_level <= `DSTC_LVL_OFF;
        boost_rail <= `DSTC_LVL_OFF;
      end else if (hiv_b) begin
        output_level <= 4'h8;
        boost_rail <= 4'h8;
      end else begin
        // fast pin low forces the low level on the linear stage only
        output_level <= {1'b0, ~fast_s & voltage_select_bit_b, boost_b, voltage_select_bit_b & fast_s} |
                        {3'b000, ~voltage_select_bit_b & 1'b0};
        boost_rail <= {2'b00, boost_b, voltage_select_bit_b};
      end
      flag_r[`DSTC_ST_LOWI] <= en_b & lowi_s;
      flag_r[`DSTC_ST_UV] <= en_b & uv_s & ~boost_b;
      flag_r[`DSTC_ST_TF] <= en_b & tlim_s;
      flag_r[`DSTC_ST_OT] <= ot_s;
      flag_r[`DSTC_ST_OL] <= ol_flag_r;
      detected_tone_output_o <= 1'b0;
      detected_tone_output_oe <= det_s;
    end
  end
  assign status = {boost_b, voltage_select_bit_b, en_b, flag_r};

endmodule

//--- dstc_top_tb.sv
/* self-checking bench for dstc_top: apb master, pin drivers, scenarios.
   assumes dstc_checker and dstc_key_src are compiled first. */
`timescale 1ns/100ps
`include "dstc_defines.vh"
module dstc_top_tb;
  localparam TON = 50;
  localparam TOFF = 500;
  localparam logic [11:0] ctl_a = `DSTC_CTRL_ADDR;
  localparam logic [11:0] st_a = `DSTC_STAT_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic gate_in, key_in, key_en, txp_in, tone_out, txon_out, det_in, dto_o, dto_oe;
  logic fast_in, pwr_en;
  logic [3:0] lvl, rail;
  logic [4:0] mon;
  int miscompares = 0;
  int checks_done = 0;
  dstc_top #(.TON_CYC(TON), .TOFF_CYC(TOFF)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tone_gate_input(gate_in), .external_keying_input(key_in), .tone_tx_path_pin(txp_in),
    .tone_output_pin(tone_out), .tone_tx_path_on(txon_out), .tone_detect_input(det_in),
    .detected_tone_output_o(dto_o), .detected_tone_output_oe(dto_oe),
    .fast_level_pin(fast_in), .power_enable(pwr_en), .output_level(lvl), .boost_rail(rail),
    .undervoltage_mon(mon[1]), .tone_limit_mon(mon[2]), .low_current_mon(mon[0]),
    .overload_mon(mon[4]), .overtemp_mon(mon[3]));
  dstc_key_src u_key (.enable(key_en), .key(key_in));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic in_range(input int n, input int lo, input int hi);
    check({31'h0, n >= lo && n <= hi}, 32'h0000_0001);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    check(rd, exp);
  endtask
  task automatic t_on(output int n);
    n = 0;
    while (tone_out !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // last high cycle, once the pin has rested longer than a full period
  task automatic t_off(output int last);
    int n;
    n = 0;
    last = 0;
    while (n - last < 2400 && n < 20000) begin
      @(posedge pclk);
      n++;
      if (tone_out === 1'b1)
        last = n;
    end
  endtask
  task automatic wait_pwr(input logic v, input int drop, output int n);
    n = 0;
    while (pwr_en !== v && n < 1000) begin
      @(posedge pclk);
      n++;
      if (n == drop)
        mon <= 5'h00;
    end
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_regs;
    logic [31:0] d;
    logic e;
    rd_chk(ctl_a, 32'h0000_0000);
    rd_chk(st_a, 32'h0000_0000);
    wr(ctl_a, 32'h0000_00ff);
    wr(st_a, 32'h0000_0000);
    rd_chk(ctl_a, 32'h0000_00ff);
    rd_chk(st_a, 32'h0000_00e0);
    apb(1'b0, 12'h008, 32'h0000_0000, d, e);
    check({31'h0, e}, 32'h0000_0001);
    check(d, 32'h0000_0000);
  endtask
  task automatic s_levels;
    logic [7:0] c [8] = '{8'h02, 8'h01, 8'h05, 8'h03, 8'h07, 8'h03, 8'h07, 8'h87};
    logic [7:0] f = 8'h9f;
    logic [3:0] ol [8] = '{4'h0, 4'h0, 4'h2, 4'h1, 4'h3, 4'h4, 4'h6, 4'h8};
    logic [3:0] br [8] = '{4'h0, 4'h0, 4'h2, 4'h1, 4'h3, 4'h1, 4'h3, 4'h8};
    for (int i = 0; i < 8; i++) begin
      fast_in <= f[i];
      wr(ctl_a, {24'h00_0000, c[i]});
      cyc(10);
      check(32'(pwr_en), 32'(c[i][0]));
      check(32'(lvl), 32'(ol[i]));
      check(32'(rail), 32'(br[i]));
    end
    fast_in <= 1'b1;
  endtask
  task automatic s_tone;
    int n;
    txp_in <= 1'b1;
    wr(ctl_a, 32'h0000_0001);
    gate_in <= 1'b1;
    t_on(n);
    in_range(n, 0, 2400);
    cyc(3000);
    gate_in <= 1'b0;
    t_off(n);
    in_range(n, 1000, 3600);
    key_en <= 1'b1;
    t_on(n);
    in_range(n, 2100, 4700);
    cyc(3000);
    key_en <= 1'b0;
    t_off(n);
    in_range(n, 3296, 5800);
    wr(ctl_a, 32'h0000_0019);
    t_on(n);
    in_range(n, 0, 10);
    wr(ctl_a, 32'h0000_0001);
    txp_in <= 1'b0;
    t_off(n);
  endtask
  task automatic s_flags;
    wr(ctl_a, 32'h0000_0021);
    for (int i = 0; i < 5; i++) begin
      mon <= 5'h01 << i;
      cyc(10);
      rd_chk(st_a, 32'h0000_0020 | (32'h0000_0001 << i));
    end
    mon <= 5'h02;
    wr(ctl_a, 32'h0000_0025);
    cyc(10);
    rd_chk(st_a, 32'h0000_00a0);
    mon <= 5'h00;
    det_in <= 1'b1;
    cyc(10);
    check(32'(dto_oe), 32'h0000_0001);
    det_in <= 1'b0;
    cyc(10);
    rd_chk(st_a, 32'h0000_00a0);
  endtask
  task automatic s_ovl;
    int n;
    wr(ctl_a, 32'h0000_0001);
    mon <= 5'h10;
    wait_pwr(1'b0, 0, n);
    in_range(n, TON, TON + 20);
    wait_pwr(1'b1, 0, n);
    wait_pwr(1'b0, 0, n);
    in_range(n, TON, TON + 20);
    wait_pwr(1'b1, TOFF - 40, n);
    in_range(n, TOFF - 5, TOFF + 5);
    rd_chk(st_a, 32'h0000_0030);
    cyc(TON + 20);
    rd_chk(st_a, 32'h0000_0020);
    check(32'(pwr_en), 32'h0000_0001);
    wr(ctl_a, 32'h0000_0000);
    cyc(10);
    check(32'(pwr_en), 32'h0000_0000);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {gate_in, key_en, txp_in, det_in} = 4'h0;
    fast_in = 1'b1;
    mon = 5'h00;
    cyc(20);
    presetn <= 1'b1;
    s_regs;
    s_levels;
    s_tone;
    s_flags;
    s_ovl;
    print_verdict;
  end
  initial begin
    #(1500000);
    miscompares++;
    print_verdict;
  end
endmodule
bind dstc_top dstc_checker #(.TON_CYC(TON_CYC), .TOFF_CYC(TOFF_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .tone_output_pin(tone_output_pin),
  .tone_tx_path_pin(tone_tx_path_pin), .tone_tx_path_on(tone_tx_path_on),
  .tone_detect_input(tone_detect_input), .detected_tone_output_o(detected_tone_output_o),
  .detected_tone_output_oe(detected_tone_output_oe), .power_enable(power_enable),
  .output_level(output_level), .boost_rail(boost_rail), .overtemp_mon(overtemp_mon));
